// >>> verilog/serial_flash_volatile_config.sv
// Function
// - vcfg bits 7:4 give dummy clocks after each fast read command.
// - dummy codes 0000 and 1111 both select the default dummy count.
// - vcfg bit 3 enables or disables execute in place.
// - feature digit 2 or 4 forces execute in place, ignoring bit 3.
// - wrap field 00/01/10 gives 16/32/64 byte wrap, 11 sequential default.
// - wrap read starts at given address, returns to aligned block start.
// - sequential setting reads consecutive addresses without wrapping.
// - vcfg writes apply at once; read command returns register contents.
// - ecfg bit 7 low selects quad, bit 6 low dual, ones extended.
// - both low means quad; change acts after the ecfg write command.
// - nonvolatile dual/quad bits take effect at power-up, quad if both low.
// - ecfg bit 4 high enables hold/reset pin where offered.
// - ecfg bit 3 low enables program accelerator; default disabled.
// - ecfg bits 2:0 hold drive strength, default 111.
// - ecfg read and write accepted in extended, dual and quad.
// - reset returns the volatile registers to their defaults.
`timescale 1ns/1ps

module serial_flash_volatile_config #(
	parameter int FEATURE_DIGIT = 1,
	parameter bit HOLD_RESET_AVAIL = 1'b1,
	parameter int ADDR_W = 24
) (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic SCK,
	input wire logic CS_N,
	input wire logic [3:0] DQ_IN,
	output logic [3:0] DQ_OUT,
	output logic [3:0] DQ_OE,
	input wire logic NV_QUAD_EN_N,
	input wire logic NV_DUAL_EN_N,
	output logic [ADDR_W-1:0] MEM_ADDR,
	input wire logic [7:0] MEM_DATA,
	output flash_vcfg_pkg::cfg_t CONFIG
);
	import flash_vcfg_pkg::*;

	generate
		if (ADDR_W != 24) begin : g_bad_addr
			$error("ADDR_W must be 24");
		end
		if (FEATURE_DIGIT < 0 || FEATURE_DIGIT > 9) begin : g_bad_digit
			$error("FEATURE_DIGIT must be a single digit");
		end
	endgenerate

	typedef enum logic [2:0] {S_CMD, S_ADDR, S_DUMMY, S_RDATA, S_WDATA, S_IGNORE} state_t;
	typedef enum logic [1:0] {SRC_MEM, SRC_VCFG, SRC_ECFG} src_t;

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic sck_m_r, sck_s_r, sck_d_r;
	logic cs_m_r, cs_s_r;
	logic [3:0] dq_m_r, dq_s_r;
	logic [1:0] nv_m_r, nv_s_r;

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			sck_m_r <= 1'b0;
			sck_s_r <= 1'b0;
			sck_d_r <= 1'b0;
			cs_m_r <= 1'b1;
			cs_s_r <= 1'b1;
			dq_m_r <= 4'h0;
			dq_s_r <= 4'h0;
			nv_m_r <= 2'h3;
			nv_s_r <= 2'h3;
		end else begin
			sck_m_r <= SCK;
			sck_s_r <= sck_m_r;
			sck_d_r <= sck_s_r;
			cs_m_r <= CS_N;
			cs_s_r <= cs_m_r;
			dq_m_r <= DQ_IN;
			dq_s_r <= dq_m_r;
			nv_m_r <= {NV_QUAD_EN_N, NV_DUAL_EN_N};
			nv_s_r <= nv_m_r;
		end
	end

	logic sck_rise, sck_fall;
	assign sck_rise = sck_s_r & ~sck_d_r;
	assign sck_fall = ~sck_s_r & sck_d_r;

	////////////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic proto_t decode_proto(input logic quad_n, input logic dual_n);
		if (!quad_n) begin
			decode_proto = PROTO_QUAD;
		end else if (!dual_n) begin
			decode_proto = PROTO_DUAL;
		end else begin
			decode_proto = PROTO_EXT;
		end
	endfunction : decode_proto

	function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a,
			input logic [1:0] wrap);
		logic [ADDR_W-1:0] m;
		logic [ADDR_W-1:0] inc;
		m = '0;
		inc = a + 1'b1;
		unique case (wrap)
			WRAP_16: m = ADDR_W'(8'h0F);
			WRAP_32: m = ADDR_W'(8'h1F);
			WRAP_64: m = ADDR_W'(8'h3F);
			WRAP_SEQ: m = '0;
		endcase
		if (wrap == WRAP_SEQ) begin
			next_addr = inc;
		end else begin
			next_addr = (a & ~m) | (inc & m);
		end
	endfunction : next_addr

	////////////////////////////////////////////////////////////////////////////////
	// command engine and registers
	state_t st_r, st_nxt;
	src_t src_r, src_nxt;
	proto_t proto_r, proto_nxt;
	logic [4:0] cnt_r, cnt_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic [ADDR_W-1:0] addr_r, addr_nxt;
	logic [3:0] dum_r, dum_nxt;
	logic [7:0] out_r, out_nxt;
	logic [2:0] ocnt_r, ocnt_nxt;
	logic [3:0] oe_r, oe_nxt;
	logic [7:0] vcfg_r, vcfg_nxt;
	logic [7:0] ecfg_r, ecfg_nxt;
	logic [1:0] init_r, init_nxt;

	logic [4:0] w;
	logic [3:0] lanes;
	logic [7:0] sh_in;
	logic [ADDR_W-1:0] addr_in;
	logic [4:0] cnt_sum;
	logic [3:0] dummy_code, dummy_eff;

	always_comb begin
		unique case (proto_r)
			PROTO_EXT: begin
				w = 5'h01;
				lanes = 4'h2;
				sh_in = {sh_r[6:0], dq_s_r[0]};
				addr_in = {addr_r[ADDR_W-2:0], dq_s_r[0]};
			end
			PROTO_DUAL: begin
				w = 5'h02;
				lanes = 4'h3;
				sh_in = {sh_r[5:0], dq_s_r[1:0]};
				addr_in = {addr_r[ADDR_W-3:0], dq_s_r[1:0]};
			end
			default: begin
				w = 5'h04;
				lanes = 4'hF;
				sh_in = {sh_r[3:0], dq_s_r};
				addr_in = {addr_r[ADDR_W-5:0], dq_s_r};
			end
		endcase
	end

	assign cnt_sum = cnt_r + w;
	assign dummy_code = vcfg_r[VCFG_DUMMY_LSB +: 4];
	assign dummy_eff = (dummy_code == DUMMY_CODE_ZERO || dummy_code == DUMMY_CODE_FULL) ?
		DUMMY_DEFAULT : dummy_code;

	always_comb begin
		st_nxt = st_r;
		src_nxt = src_r;
		proto_nxt = proto_r;
		cnt_nxt = cnt_r;
		sh_nxt = sh_r;
		addr_nxt = addr_r;
		dum_nxt = dum_r;
		out_nxt = out_r;
		ocnt_nxt = ocnt_r;
		oe_nxt = oe_r;
		vcfg_nxt = vcfg_r;
		ecfg_nxt = ecfg_r;
		init_nxt = init_r;
		if (init_r != INIT_DONE) begin
			init_nxt = init_r + 2'h1;
			if (init_r == INIT_LOAD) begin
				ecfg_nxt[ECFG_QUAD_BIT] = nv_s_r[1];
				ecfg_nxt[ECFG_DUAL_BIT] = nv_s_r[0];
			end
		end else if (cs_s_r) begin
			st_nxt = S_CMD;
			cnt_nxt = 5'h00;
			ocnt_nxt = 3'h0;
			oe_nxt = 4'h0;
			proto_nxt = decode_proto(ecfg_r[ECFG_QUAD_BIT], ecfg_r[ECFG_DUAL_BIT]);
		end else begin
			if (sck_rise) begin
				unique case (st_r)
					S_CMD: begin
						sh_nxt = sh_in;
						cnt_nxt = cnt_sum;
						if (cnt_sum == BYTE_BITS) begin
							cnt_nxt = 5'h00;
							st_nxt = S_IGNORE;
							unique case (sh_in)
								CMD_FAST_READ: st_nxt = S_ADDR;
								CMD_RD_VCFG: begin
									st_nxt = S_RDATA;
									src_nxt = SRC_VCFG;
								end
								CMD_RD_ECFG: begin
									st_nxt = S_RDATA;
									src_nxt = SRC_ECFG;
								end
								CMD_WR_VCFG: begin
									st_nxt = S_WDATA;
									src_nxt = SRC_VCFG;
								end
								CMD_WR_ECFG: begin
									st_nxt = S_WDATA;
									src_nxt = SRC_ECFG;
								end
								default: st_nxt = S_IGNORE;
							endcase
						end
					end
					S_ADDR: begin
						addr_nxt = addr_in;
						cnt_nxt = cnt_sum;
						if (cnt_sum == ADDR_BITS) begin
							st_nxt = S_DUMMY;
							dum_nxt = 4'h0;
						end
					end
					S_DUMMY: begin
						dum_nxt = dum_r + 4'h1;
						if (dum_r + 4'h1 == dummy_eff) begin
							st_nxt = S_RDATA;
							src_nxt = SRC_MEM;
						end
					end
					S_WDATA: begin
						sh_nxt = sh_in;
						cnt_nxt = cnt_sum;
						if (cnt_sum == BYTE_BITS) begin
							st_nxt = S_IGNORE;
							if (src_r == SRC_VCFG) begin
								vcfg_nxt = sh_in;
								vcfg_nxt[VCFG_RSVD_BIT] = 1'b0;
							end else begin
								ecfg_nxt = sh_in;
								ecfg_nxt[ECFG_RSVD_BIT] = 1'b0;
							end
						end
					end
					S_RDATA, S_IGNORE: begin
						st_nxt = st_r;
					end
					default: st_nxt = S_IGNORE;
				endcase
			end
			if (sck_fall && st_r == S_RDATA) begin
				oe_nxt = lanes;
				ocnt_nxt = ocnt_r + w[2:0];
				if (ocnt_r == 3'h0) begin
					unique case (src_r)
						SRC_MEM: begin
							out_nxt = MEM_DATA;
							addr_nxt = next_addr(addr_r, vcfg_r[VCFG_WRAP_LSB +: 2]);
						end
						SRC_VCFG: out_nxt = vcfg_r;
						default: out_nxt = ecfg_r;
					endcase
				end else begin
					out_nxt = out_r << w;
				end
			end
		end
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			st_r <= S_CMD;
			src_r <= SRC_MEM;
			proto_r <= PROTO_EXT;
			cnt_r <= 5'h00;
			sh_r <= 8'h00;
			addr_r <= '0;
			dum_r <= 4'h0;
			out_r <= 8'h00;
			ocnt_r <= 3'h0;
			oe_r <= 4'h0;
			vcfg_r <= VCFG_RESET;
			ecfg_r <= ECFG_RESET;
			init_r <= 2'h0;
		end else begin
			st_r <= st_nxt;
			src_r <= src_nxt;
			proto_r <= proto_nxt;
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			addr_r <= addr_nxt;
			dum_r <= dum_nxt;
			out_r <= out_nxt;
			ocnt_r <= ocnt_nxt;
			oe_r <= oe_nxt;
			vcfg_r <= vcfg_nxt;
			ecfg_r <= ecfg_nxt;
			init_r <= init_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs
	always_comb begin
		unique case (proto_r)
			PROTO_EXT: DQ_OUT = {2'b00, out_r[7], 1'b0};
			PROTO_DUAL: DQ_OUT = {2'b00, out_r[7:6]};
			default: DQ_OUT = out_r[7:4];
		endcase
	end

	assign DQ_OE = oe_r;
	assign MEM_ADDR = addr_r;

	always_comb begin
		CONFIG.protocol = proto_r;
		if (FEATURE_DIGIT == 2 || FEATURE_DIGIT == 4) begin
			CONFIG.execute_in_place = 1'b1;
		end else begin
			CONFIG.execute_in_place = ~vcfg_r[VCFG_XIP_BIT];
		end
		CONFIG.hold_reset_en = HOLD_RESET_AVAIL & ecfg_r[ECFG_HOLD_BIT];
		CONFIG.accel_en = ~ecfg_r[ECFG_ACCEL_BIT];
		CONFIG.drive_strength = ecfg_r[ECFG_DRIVE_LSB +: 3];
		CONFIG.dummy_cycles = dummy_eff;
		CONFIG.wrap = vcfg_r[VCFG_WRAP_LSB +: 2];
	end

endmodule : serial_flash_volatile_config

// >>> inc/flash_vcfg_pkg.sv
package flash_vcfg_pkg;

	// command codes
	localparam logic [7:0] CMD_FAST_READ = 8'h0B;
	localparam logic [7:0] CMD_RD_VCFG = 8'h85;
	localparam logic [7:0] CMD_WR_VCFG = 8'h81;
	localparam logic [7:0] CMD_RD_ECFG = 8'h65;
	localparam logic [7:0] CMD_WR_ECFG = 8'h61;

	// volatile_config fields
	localparam int VCFG_DUMMY_LSB = 4;
	localparam int VCFG_XIP_BIT = 3;
	localparam int VCFG_RSVD_BIT = 2;
	localparam int VCFG_WRAP_LSB = 0;
	localparam logic [7:0] VCFG_RESET = 8'hFB;

	// enhanced_volatile_config fields
	localparam int ECFG_QUAD_BIT = 7;
	localparam int ECFG_DUAL_BIT = 6;
	localparam int ECFG_RSVD_BIT = 5;
	localparam int ECFG_HOLD_BIT = 4;
	localparam int ECFG_ACCEL_BIT = 3;
	localparam int ECFG_DRIVE_LSB = 0;
	localparam logic [7:0] ECFG_RESET = 8'hDF;

	// dummy count codes and link framing
	localparam logic [3:0] DUMMY_CODE_ZERO = 4'h0;
	localparam logic [3:0] DUMMY_CODE_FULL = 4'hF;
	localparam logic [3:0] DUMMY_DEFAULT = 4'hF;
	localparam logic [1:0] WRAP_16 = 2'h0;
	localparam logic [1:0] WRAP_32 = 2'h1;
	localparam logic [1:0] WRAP_64 = 2'h2;
	localparam logic [1:0] WRAP_SEQ = 2'h3;
	localparam logic [4:0] BYTE_BITS = 5'h08;
	localparam logic [4:0] ADDR_BITS = 5'h18;
	localparam logic [1:0] INIT_DONE = 2'h3;
	localparam logic [1:0] INIT_LOAD = 2'h2;

	typedef enum logic [1:0] {PROTO_EXT, PROTO_DUAL, PROTO_QUAD} proto_t;

	typedef struct packed {
		proto_t protocol;
		logic execute_in_place;
		logic hold_reset_en;
		logic accel_en;
		logic [2:0] drive_strength;
		logic [3:0] dummy_cycles;
		logic [1:0] wrap;
	} cfg_t;

endpackage : flash_vcfg_pkg

// >>> tb/serial_flash_volatile_config_assertions.sv
`timescale 1ns/1ps
module serial_flash_volatile_config_assertions #(
	parameter int ADDR_W = 24
) (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic SCK,
	input wire logic CS_N,
	input wire logic [3:0] DQ_OUT,
	input wire logic [3:0] DQ_OE,
	input wire logic NV_QUAD_EN_N,
	input wire logic NV_DUAL_EN_N,
	input wire flash_vcfg_pkg::cfg_t CONFIG
);
	import flash_vcfg_pkg::*;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	property p_dummy;
		CONFIG.dummy_cycles != 4'h0;
	endproperty
	a_dummy: assert property (p_dummy) else $error("dummy zero");
	property p_lanes;
		DQ_OE != 4'h0 |-> DQ_OE == (CONFIG.protocol == PROTO_QUAD ? 4'hF :
			CONFIG.protocol == PROTO_DUAL ? 4'h3 : 4'h2);
	endproperty
	a_lanes: assert property (p_lanes) else $error("lane enables");
	property p_proto;
		$changed(CONFIG.protocol) |-> CS_N && $past(CS_N);
	endproperty
	a_proto: assert property (p_proto) else $error("protocol while selected");
	property p_apply;
		$changed({CONFIG.execute_in_place, CONFIG.hold_reset_en, CONFIG.accel_en,
			CONFIG.drive_strength, CONFIG.dummy_cycles, CONFIG.wrap}) |-> !$past(CS_N, 3);
	endproperty
	a_apply: assert property (p_apply) else $error("config change");
	property p_idle;
		CS_N [*5] |-> DQ_OE == 4'h0;
	endproperty
	a_idle: assert property (p_idle) else $error("drive while idle");
	property p_out;
		$changed(DQ_OUT) && DQ_OE != 4'h0 && $past(DQ_OE) != 4'h0 |-> !$past(SCK, 2);
	endproperty
	a_out: assert property (p_out) else $error("output timing");
	property p_reset;
		$fell(RST) |-> CONFIG.drive_strength == 3'h7 && CONFIG.hold_reset_en &&
			!CONFIG.accel_en && CONFIG.wrap == WRAP_SEQ;
	endproperty
	a_reset: assert property (p_reset) else $error("reset values");
	property p_nv;
		$fell(RST) ##6 1 |-> CONFIG.protocol == (!NV_QUAD_EN_N ? PROTO_QUAD :
			!NV_DUAL_EN_N ? PROTO_DUAL : PROTO_EXT);
	endproperty
	a_nv: assert property (p_nv) else $error("power-up protocol");
endmodule : serial_flash_volatile_config_assertions

bind serial_flash_volatile_config serial_flash_volatile_config_assertions #(.ADDR_W(ADDR_W))
	sva_i (.CLOCK(CLOCK), .RST(RST), .SCK(SCK), .CS_N(CS_N), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE),
	.NV_QUAD_EN_N(NV_QUAD_EN_N), .NV_DUAL_EN_N(NV_DUAL_EN_N), .CONFIG(CONFIG));

// >>> tb/flash_host_model.sv
`timescale 1ns/1ps
module flash_host_model (
	input wire logic clk,
	output logic sck,
	output logic cs_n,
	output logic [3:0] dq,
	input wire logic [3:0] dq_out,
	input wire logic [3:0] dq_oe
);
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		dq = 4'h0;
	end
	// slow sck keeps every read type within its clock limit
	task automatic tick(input logic [3:0] v, input int w, output logic [3:0] r);
		logic [3:0] nd;
		@(posedge clk) #1;
		nd = ~dq;
		for (int j = 0; j < w; j++) nd[j] = v[j];
		dq = nd;
		repeat (4) @(posedge clk);
		#1;
		// lanes not driven by the flash read back inverted
		r = dq_out ^ ~dq_oe;
		sck = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		sck = 1'b0;
	endtask : tick
	task automatic xbyte(input logic [7:0] tx, input int w, output logic [7:0] rx);
		logic [3:0] r;
		for (int k = 8 - w; k >= 0; k -= w) begin
			tick(4'(tx >> k), w, r);
			for (int j = 0; j < w; j++) rx[k + j] = (w == 1) ? r[1] : r[j];
		end
	endtask : xbyte
	task automatic start();
		@(posedge clk) #1 cs_n = 1'b0;
	endtask : start
	task automatic stop();
		repeat (4) @(posedge clk);
		#1 cs_n = 1'b1;
		repeat (8) @(posedge clk);
		#1;
	endtask : stop
endmodule : flash_host_model

// >>> tb/serial_flash_volatile_config_tb.sv
`timescale 1ns/1ps
module serial_flash_volatile_config_tb;
	import flash_vcfg_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic nv_quad_n = 1'b1;
	logic nv_dual_n = 1'b1;
	logic sck, cs_n;
	logic [3:0] dq_in, dq_out, dq_oe;
	logic [23:0] mem_addr;
	logic [7:0] mem_data;
	cfg_t cfg;
	int bad_count = 0;
	int checked = 0;
	always #20 clock = ~clock;
	assign mem_data = mem_addr[7:0] ^ 8'h5A;
	serial_flash_volatile_config serial_flash_volatile_config_i (.CLOCK(clock), .RST(rst),
		.SCK(sck), .CS_N(cs_n), .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE(dq_oe),
		.NV_QUAD_EN_N(nv_quad_n), .NV_DUAL_EN_N(nv_dual_n), .MEM_ADDR(mem_addr),
		.MEM_DATA(mem_data), .CONFIG(cfg));
	flash_host_model flash_host_model_i (.clk(clock), .sck(sck), .cs_n(cs_n), .dq(dq_in),
		.dq_out(dq_out), .dq_oe(dq_oe));
	////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : summarize
	task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] s);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : cmp8
	task automatic do_reset();
		@(posedge clock) #1 rst = 1'b1;
		repeat (6) @(posedge clock);
		#1 rst = 1'b0;
		repeat (8) @(posedge clock);
		#1;
	endtask : do_reset
	task automatic rd(input logic [7:0] c, input int w, output logic [7:0] v);
		flash_host_model_i.start();
		flash_host_model_i.xbyte(c, w, v);
		flash_host_model_i.xbyte(8'h00, w, v);
		flash_host_model_i.stop();
	endtask : rd
	task automatic wr(input logic [7:0] c, input logic [7:0] d, input int w);
		logic [7:0] v;
		flash_host_model_i.start();
		flash_host_model_i.xbyte(c, w, v);
		flash_host_model_i.xbyte(d, w, v);
		flash_host_model_i.stop();
	endtask : wr
	initial begin
		#400000;
		bad_count++;
		summarize();
	end
	initial begin
		logic [7:0] v;
		logic [3:0] r;
		logic [23:0] a, sz;
		do_reset();
		cmp8("dummy15", 8'h0F, 8'(cfg.dummy_cycles));
		cmp8("xip reset", 8'h00, 8'(cfg.execute_in_place));
		rd(CMD_RD_VCFG, 1, v);
		cmp8("vcfg", VCFG_RESET, v);
		rd(CMD_RD_ECFG, 1, v);
		cmp8("ecfg", ECFG_RESET, v);
		wr(CMD_WR_VCFG, 8'h04, 1);
		cmp8("dummy0", 8'h0F, 8'(cfg.dummy_cycles));
		cmp8("xip", 8'h01, 8'(cfg.execute_in_place));
		rd(CMD_RD_VCFG, 1, v);
		cmp8("vcfg rsvd", 8'h00, v);
		for (int m = 0; m < 4; m++) begin
			wr(CMD_WR_VCFG, {4'(m + 1), 2'b10, 2'(m)}, 1);
			cmp8("dummy", 8'(m + 1), 8'(cfg.dummy_cycles));
			cmp8("wrap", 8'(m), 8'(cfg.wrap));
			cmp8("xip off", 8'h00, 8'(cfg.execute_in_place));
			flash_host_model_i.start();
			flash_host_model_i.xbyte(CMD_FAST_READ, 1, v);
			flash_host_model_i.xbyte(8'h00, 1, v);
			flash_host_model_i.xbyte(8'h00, 1, v);
			flash_host_model_i.xbyte(8'h3E, 1, v);
			for (int d = 0; d <= m; d++) flash_host_model_i.tick(4'h0, 1, r);
			for (int i = 0; i < 3; i++) begin
				flash_host_model_i.xbyte(8'h00, 1, v);
				sz = 24'h10 << m;
				a = 24'h3E + 24'(i);
				if (m < 3) a = (24'h3E & ~(sz - 24'h1)) | (a & (sz - 24'h1));
				cmp8("read", a[7:0] ^ 8'h5A, v);
			end
			flash_host_model_i.stop();
		end
		wr(8'hAA, 8'h00, 1);
		rd(CMD_RD_VCFG, 1, v);
		cmp8("vcfg kept", 8'h4B, v);
		wr(CMD_WR_ECFG, 8'hBF, 1);
		cmp8("dual", 8'(PROTO_DUAL), 8'(cfg.protocol));
		rd(CMD_RD_ECFG, 2, v);
		cmp8("ecfg dual", 8'h9F, v);
		wr(CMD_WR_ECFG, 8'h3F, 2);
		cmp8("quad", 8'(PROTO_QUAD), 8'(cfg.protocol));
		wr(CMD_WR_ECFG, 8'hE5, 4);
		cmp8("ext", 8'(PROTO_EXT), 8'(cfg.protocol));
		cmp8("drive", 8'h05, 8'(cfg.drive_strength));
		cmp8("accel", 8'h01, 8'(cfg.accel_en));
		cmp8("hold", 8'h00, 8'(cfg.hold_reset_en));
		rd(CMD_RD_ECFG, 1, v);
		cmp8("ecfg ext", 8'hC5, v);
		nv_quad_n = 1'b0;
		do_reset();
		cmp8("nv quad", 8'(PROTO_QUAD), 8'(cfg.protocol));
		rd(CMD_RD_ECFG, 4, v);
		cmp8("ecfg nv", 8'h5F, v);
		summarize();
	end
endmodule : serial_flash_volatile_config_tb
